// File: nlid_pkg.sv
package nlid_pkg;
	localparam int NLID_NIB_W = 4;
	localparam int NLID_DADDR_W = 7;
	localparam int NLID_DMEM_DEPTH = 128;
	localparam int NLID_IDX_W = 12;
	localparam int NLID_TBL_W = 8;
	localparam int NLID_CNT_W = 16;
	localparam logic [NLID_NIB_W-1:0] NLID_WORK_RST = 4'h0;
	localparam logic NLID_CARRY_RST = 1'b0;
	localparam logic [NLID_IDX_W-1:0] NLID_IDX_RST = 12'h000;
	localparam logic [NLID_IDX_W-1:0] NLID_IDX_STEP = 12'h001;
	localparam logic NLID_ONE = 1'b1;
	localparam logic NLID_ZERO = 1'b0;
	localparam int NLID_TBL_HI_LSB = 4;
	localparam int NLID_TBL_LO_LSB = 0;
	localparam int NLID_CNT_NIB0_LSB = 0;
	localparam int NLID_CNT_NIB1_LSB = 4;
	localparam int NLID_CNT_NIB2_LSB = 8;
	localparam int NLID_CNT_NIB3_LSB = 12;

	typedef enum logic [4:0] {
		NLID_OP_DIFF_MEM,
		NLID_OP_UNION_MEM,
		NLID_OP_ADD_CARRY_IMM,
		NLID_OP_SUB_BORROW_IMM,
		NLID_OP_ADD_IMM,
		NLID_OP_SUB_IMM,
		NLID_OP_ADD_NOCARRY_IMM,
		NLID_OP_CONJ_IMM,
		NLID_OP_DIFF_IMM,
		NLID_OP_UNION_IMM,
		NLID_OP_STORE_WORK,
		NLID_OP_LOAD_IMM_BOTH,
		NLID_OP_LOAD_WORK,
		NLID_OP_TABLE_HIGH,
		NLID_OP_TABLE_LOW,
		NLID_OP_COUNT_NIB0,
		NLID_OP_COUNT_NIB1,
		NLID_OP_COUNT_NIB2,
		NLID_OP_COUNT_NIB3
	} nlid_op_t;

	typedef enum logic [1:0] {
		NLID_ST_IDLE,
		NLID_ST_READ,
		NLID_ST_EXEC
	} nlid_state_t;

	typedef struct packed {
		nlid_op_t op;
		logic starred;
		logic use_index;
		logic [NLID_DADDR_W-1:0] addr;
		logic [NLID_NIB_W-1:0] imm;
	} nlid_cmd_t;

	localparam nlid_cmd_t NLID_CMD_RST = '{
		op: NLID_OP_LOAD_WORK,
		starred: 1'b0,
		use_index: 1'b0,
		addr: 7'h00,
		imm: 4'h0
	};
endpackage

// File: nlid_dmem.sv
`timescale 1ns/1ps
module nlid_dmem #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// File: nlid_datapath.sv
`timescale 1ns/1ps
module nlid_datapath
	import nlid_pkg::*;
#(
	parameter int DEPTH = NLID_DMEM_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire nlid_cmd_t cmd,
	output logic cmd_ready,
	output logic cmd_done,
	input wire logic idx_load,
	input wire logic [NLID_IDX_W-1:0] idx_load_value,
	input wire logic [NLID_TBL_W-1:0] table_word,
	input wire logic [NLID_CNT_W-1:0] resistance_freq_counter,
	output logic [NLID_IDX_W-1:0] index_pointer,
	output logic [NLID_NIB_W-1:0] work_nibble_reg,
	output logic carry_bit
);
	typedef struct packed {
		nlid_state_t state;
		nlid_cmd_t cmd;
		logic [NLID_NIB_W-1:0] work;
		logic carry;
		logic [NLID_IDX_W-1:0] idx;
		logic ready;
		logic done;
	} nlid_regs_t;

	localparam nlid_regs_t NLID_REGS_RST = '{
		state: NLID_ST_IDLE,
		cmd: NLID_CMD_RST,
		work: NLID_WORK_RST,
		carry: NLID_CARRY_RST,
		idx: NLID_IDX_RST,
		ready: NLID_ONE,
		done: NLID_ZERO
	};

	nlid_regs_t r;
	nlid_regs_t next_r;
	logic [NLID_NIB_W-1:0] mem_rdata;
	logic [NLID_DADDR_W-1:0] op_addr;
	logic mem_rd;
	logic mem_wr;
	logic [NLID_NIB_W-1:0] mem_wdata;
	logic [NLID_NIB_W-1:0] result;
	logic [NLID_NIB_W-1:0] addend;
	logic carry_in;
	logic [NLID_NIB_W:0] sum;
	logic write_back;
	logic write_work;
	logic carry_upd;

	// Operand location: index pointer low bits or direct address
	always_comb begin
		if (r.cmd.use_index && (r.cmd.op == NLID_OP_DIFF_MEM || r.cmd.op == NLID_OP_UNION_MEM
				|| r.cmd.op == NLID_OP_STORE_WORK || r.cmd.op == NLID_OP_LOAD_WORK)) begin
			op_addr = r.idx[NLID_DADDR_W-1:0];
		end else begin
			op_addr = r.cmd.addr;
		end
	end

	assign mem_rd = (r.state == NLID_ST_READ);

	nlid_dmem #(
		.WIDTH(NLID_NIB_W),
		.DEPTH(DEPTH),
		.AW(NLID_DADDR_W)
	) u_dmem (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(mem_wr),
		.wr_addr(op_addr),
		.wr_data(mem_wdata),
		.rd_en(mem_rd),
		.rd_addr(op_addr),
		.rd_data(mem_rdata)
	);

	// Shared adder for the immediate arithmetic group
	always_comb begin
		addend = r.cmd.imm;
		carry_in = NLID_ZERO;
		case (r.cmd.op)
			NLID_OP_ADD_CARRY_IMM: begin
				carry_in = r.carry;
			end
			NLID_OP_SUB_BORROW_IMM: begin
				addend = ~r.cmd.imm;
				carry_in = r.carry;
			end
			NLID_OP_SUB_IMM: begin
				addend = ~r.cmd.imm;
				carry_in = NLID_ONE;
			end
			default: begin
				carry_in = NLID_ZERO;
			end
		endcase
		sum = {1'b0, mem_rdata} + {1'b0, addend} + {{NLID_NIB_W{1'b0}}, carry_in};
	end

	// Result, destinations and carry effect per operation
	always_comb begin
		result = sum[NLID_NIB_W-1:0];
		write_back = r.cmd.starred;
		write_work = NLID_ONE;
		carry_upd = NLID_ZERO;
		case (r.cmd.op)
			NLID_OP_DIFF_MEM: begin
				result = mem_rdata ^ r.work;
			end
			NLID_OP_UNION_MEM: begin
				result = mem_rdata | r.work;
			end
			NLID_OP_ADD_CARRY_IMM, NLID_OP_SUB_BORROW_IMM, NLID_OP_ADD_IMM, NLID_OP_SUB_IMM: begin
				carry_upd = NLID_ONE;
			end
			NLID_OP_ADD_NOCARRY_IMM: begin
				carry_upd = NLID_ZERO;
			end
			NLID_OP_CONJ_IMM: begin
				result = mem_rdata & r.cmd.imm;
			end
			NLID_OP_DIFF_IMM: begin
				result = mem_rdata ^ r.cmd.imm;
			end
			NLID_OP_UNION_IMM: begin
				result = mem_rdata | r.cmd.imm;
			end
			NLID_OP_STORE_WORK: begin
				result = r.work;
				write_back = NLID_ONE;
				write_work = NLID_ZERO;
			end
			NLID_OP_LOAD_IMM_BOTH: begin
				result = r.cmd.imm;
				write_back = NLID_ONE;
			end
			NLID_OP_LOAD_WORK: begin
				result = mem_rdata;
				write_back = NLID_ZERO;
			end
			NLID_OP_TABLE_HIGH: begin
				result = table_word[NLID_TBL_HI_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			NLID_OP_TABLE_LOW: begin
				result = table_word[NLID_TBL_LO_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			NLID_OP_COUNT_NIB0: begin
				result = resistance_freq_counter[NLID_CNT_NIB0_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			NLID_OP_COUNT_NIB1: begin
				result = resistance_freq_counter[NLID_CNT_NIB1_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			NLID_OP_COUNT_NIB2: begin
				result = resistance_freq_counter[NLID_CNT_NIB2_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			NLID_OP_COUNT_NIB3: begin
				result = resistance_freq_counter[NLID_CNT_NIB3_LSB +: NLID_NIB_W];
				write_back = NLID_ONE;
			end
			default: begin
				write_back = NLID_ZERO;
				write_work = NLID_ZERO;
			end
		endcase
	end

	assign mem_wr = (r.state == NLID_ST_EXEC) && write_back;
	assign mem_wdata = result;

	always_comb begin
		next_r = r;
		next_r.done = NLID_ZERO;
		case (r.state)
			NLID_ST_IDLE: begin
				if (cmd_valid) begin
					next_r.cmd = cmd;
					next_r.state = NLID_ST_READ;
					next_r.ready = NLID_ZERO;
				end else if (idx_load) begin
					next_r.idx = idx_load_value;
				end
			end
			NLID_ST_READ: begin
				next_r.state = NLID_ST_EXEC;
			end
			NLID_ST_EXEC: begin
				if (write_work) begin
					next_r.work = result;
				end
				if (carry_upd) begin
					next_r.carry = sum[NLID_NIB_W];
				end
				if (r.cmd.starred && (r.cmd.op == NLID_OP_TABLE_HIGH
						|| r.cmd.op == NLID_OP_TABLE_LOW)) begin
					next_r.idx = r.idx + NLID_IDX_STEP;
				end
				next_r.state = NLID_ST_IDLE;
				next_r.ready = NLID_ONE;
				next_r.done = NLID_ONE;
			end
			default: begin
				next_r = NLID_REGS_RST;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= NLID_REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign cmd_ready = r.ready;
	assign cmd_done = r.done;
	assign index_pointer = r.idx;
	assign work_nibble_reg = r.work;
	assign carry_bit = r.carry;
endmodule

// File: nlid_table_rom.sv
`timescale 1ns/1ps
module nlid_table_rom
	import nlid_pkg::*;
(
	input wire logic [NLID_IDX_W-1:0] index_pointer,
	output logic [NLID_TBL_W-1:0] table_word
);
	// Nibbles differ, so high and low reads can be told apart, except where index_pointer[7:4] equals index_pointer[3:0] ^ 4'h9
	assign table_word = {index_pointer[3:0] ^ 4'h9, index_pointer[7:4]};
endmodule

// File: nlid_datapath_properties.sv
`timescale 1ns/1ps
module nlid_datapath_properties
	import nlid_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire nlid_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic idx_load,
	input wire logic [NLID_IDX_W-1:0] idx_load_value,
	input wire logic [NLID_TBL_W-1:0] table_word,
	input wire logic [NLID_CNT_W-1:0] resistance_freq_counter,
	input wire logic [NLID_IDX_W-1:0] index_pointer,
	input wire logic [NLID_NIB_W-1:0] work_nibble_reg,
	input wire logic carry_bit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic take = cmd_valid && cmd_ready;
	wire logic tbl = cmd.op == NLID_OP_TABLE_HIGH || cmd.op == NLID_OP_TABLE_LOW;
	busy_window_a: assert property (take |=> !cmd_ready [*2] ##1 cmd_ready && cmd_done)
		else $error("busy window");
	imm_load_a: assert property (take && cmd.op == NLID_OP_LOAD_IMM_BOTH
		|-> ##3 work_nibble_reg == $past(cmd.imm, 3)) else $error("imm load");
	store_keep_a: assert property (take && cmd.op == NLID_OP_STORE_WORK
		|-> ##3 $stable(work_nibble_reg)) else $error("store work");
	table_hi_a: assert property (take && cmd.op == NLID_OP_TABLE_HIGH
		|-> ##3 work_nibble_reg == $past(table_word[7:4])) else $error("table high");
	table_lo_a: assert property (take && cmd.op == NLID_OP_TABLE_LOW
		|-> ##3 work_nibble_reg == $past(table_word[3:0])) else $error("table low");
	idx_step_a: assert property (take && tbl && cmd.starred
		|-> ##3 index_pointer == $past(index_pointer, 3) + NLID_IDX_STEP)
		else $error("index step");
	idx_hold_a: assert property (take && tbl && !cmd.starred
		|-> ##3 $stable(index_pointer)) else $error("index hold");
	count_low_a: assert property (take && cmd.op == NLID_OP_COUNT_NIB0
		|-> ##3 work_nibble_reg == $past(resistance_freq_counter[3:0]))
		else $error("count low");
	count_high_a: assert property (take && cmd.op == NLID_OP_COUNT_NIB3
		|-> ##3 work_nibble_reg == $past(resistance_freq_counter[15:12]))
		else $error("count high");
	carry_keep_a: assert property (take && !(cmd.op inside {NLID_OP_ADD_CARRY_IMM,
		NLID_OP_SUB_BORROW_IMM, NLID_OP_ADD_IMM, NLID_OP_SUB_IMM}) |-> ##3 $stable(carry_bit))
		else $error("carry kept");
endmodule
bind nlid_datapath nlid_datapath_properties chk_u (.sys_clk, .rst, .cmd_valid, .cmd, .cmd_ready,
	.cmd_done, .idx_load, .idx_load_value, .table_word, .resistance_freq_counter, .index_pointer,
	.work_nibble_reg, .carry_bit);

// File: test_nlid_datapath.sv
`timescale 1ns/1ps
module test_nlid_datapath
	import nlid_pkg::*;
;
	logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, idx_load = 1'b0;
	nlid_cmd_t cmd = NLID_CMD_RST;
	logic [NLID_IDX_W-1:0] idx_load_value = 12'h000;
	logic [NLID_CNT_W-1:0] cnt = 16'hc3a5;
	logic [NLID_TBL_W-1:0] table_word;
	logic cmd_ready, cmd_done, carry_bit;
	logic [NLID_IDX_W-1:0] index_pointer;
	logic [NLID_NIB_W-1:0] work_nibble_reg;
	int mismatches = 0, n_tests = 0;
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	nlid_datapath dut_u (.sys_clk, .rst, .cmd_valid, .cmd, .cmd_ready, .cmd_done, .idx_load,
		.idx_load_value, .table_word, .resistance_freq_counter(cnt), .index_pointer,
		.work_nibble_reg, .carry_bit);
	nlid_table_rom rom_u (.index_pointer, .table_word);
	task automatic cmp(string what, logic [11:0] exp, logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic run(nlid_op_t o, logic s, logic x, logic [6:0] a, logic [3:0] d);
		int i;
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd = '{o, s, x, a, d};
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 8 && cmd_done !== 1'b1; i++) @(negedge sys_clk);
		cmp("latency", 12'h002, 12'(i));
	endtask
	// Runs one op, then reads back its memory nibble, through the index when x
	task automatic chk(nlid_op_t o, logic s, logic x, logic [6:0] a, logic [3:0] d,
		logic [3:0] ew, logic [3:0] em, logic ec);
		run(o, s, x, a, d);
		cmp("work", ew, work_nibble_reg);
		cmp("carry", ec, carry_bit);
		run(NLID_OP_LOAD_WORK, 1'b0, x, a, 4'h0);
		cmp("mem", em, work_nibble_reg);
	endtask
	task automatic setidx(logic [11:0] v);
		@(negedge sys_clk);
		idx_load = 1'b1;
		idx_load_value = v;
		@(negedge sys_clk);
		idx_load = 1'b0;
		cmp("idx", v, index_pointer);
	endtask
	task automatic t_reset();
		cmp("ready", 12'h001, cmd_ready);
		cmp("done", 12'h000, cmd_done);
		cmp("work", 12'h000, work_nibble_reg);
		cmp("carry", 12'h000, carry_bit);
		cmp("idx", 12'h000, index_pointer);
	endtask
	task automatic t_mem_logic();
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h10, 4'hf, 4'hf, 4'hf, 0);
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h11, 4'h0, 4'h0, 4'h0, 0);
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h12, 4'h5, 4'h5, 4'h5, 0);
		chk(NLID_OP_DIFF_MEM, 0, 0, 7'h10, 4'h0, 4'ha, 4'hf, 0);
		chk(NLID_OP_DIFF_MEM, 1, 0, 7'h12, 4'h0, 4'ha, 4'ha, 0);
		chk(NLID_OP_UNION_MEM, 0, 0, 7'h11, 4'h0, 4'ha, 4'h0, 0);
		chk(NLID_OP_UNION_MEM, 1, 0, 7'h12, 4'h0, 4'ha, 4'ha, 0);
	endtask
	task automatic t_arith();
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h14, 4'h9, 4'h9, 4'h9, 0);
		chk(NLID_OP_ADD_IMM, 0, 0, 7'h14, 4'h8, 4'h1, 4'h9, 1);
		chk(NLID_OP_CONJ_IMM, 0, 0, 7'h14, 4'hc, 4'h8, 4'h9, 1);
		chk(NLID_OP_DIFF_IMM, 0, 0, 7'h14, 4'hc, 4'h5, 4'h9, 1);
		chk(NLID_OP_UNION_IMM, 0, 0, 7'h14, 4'hc, 4'hd, 4'h9, 1);
		chk(NLID_OP_ADD_NOCARRY_IMM, 0, 0, 7'h14, 4'h3, 4'hc, 4'h9, 1);
		chk(NLID_OP_ADD_CARRY_IMM, 0, 0, 7'h14, 4'h6, 4'h0, 4'h9, 1);
		chk(NLID_OP_SUB_BORROW_IMM, 0, 0, 7'h14, 4'h9, 4'h0, 4'h9, 1);
		chk(NLID_OP_SUB_IMM, 0, 0, 7'h14, 4'ha, 4'hf, 4'h9, 0);
		chk(NLID_OP_ADD_IMM, 1, 0, 7'h14, 4'h1, 4'ha, 4'ha, 0);
		chk(NLID_OP_SUB_BORROW_IMM, 0, 0, 7'h14, 4'h0, 4'h9, 4'ha, 1);
	endtask
	task automatic t_index();
		setidx(12'h12c);
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h2c, 4'h3, 4'h3, 4'h3, 1);
		chk(NLID_OP_LOAD_WORK, 0, 1, 7'h10, 4'h0, 4'h3, 4'h3, 1);
		chk(NLID_OP_DIFF_MEM, 1, 1, 7'h10, 4'h0, 4'h0, 4'h0, 1);
		chk(NLID_OP_LOAD_IMM_BOTH, 0, 0, 7'h30, 4'h6, 4'h6, 4'h6, 1);
		chk(NLID_OP_STORE_WORK, 0, 1, 7'h10, 4'h0, 4'h6, 4'h6, 1);
	endtask
	task automatic t_table();
		setidx(12'hfff);
		chk(NLID_OP_TABLE_LOW, 1, 0, 7'h40, 4'h0, 4'hf, 4'hf, 1);
		cmp("idx", 12'h000, index_pointer);
		chk(NLID_OP_TABLE_HIGH, 0, 0, 7'h41, 4'h0, 4'h9, 4'h9, 1);
		cmp("idx", 12'h000, index_pointer);
		chk(NLID_OP_TABLE_HIGH, 1, 0, 7'h42, 4'h0, 4'h9, 4'h9, 1);
		cmp("idx", 12'h001, index_pointer);
	endtask
	task automatic t_count();
		for (int k = 0; k < 4; k++) begin
			chk(nlid_op_t'(NLID_OP_COUNT_NIB0 + k), 0, 0, 7'h50, 4'h0, cnt[k*4 +: 4],
				cnt[k*4 +: 4], 1);
		end
	endtask
	initial begin
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_mem_logic();
		t_arith();
		t_index();
		t_table();
		t_count();
		summarize();
	end
	// About ten times the expected run
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
endmodule
